/* core/sasq_pkg.sv */
// Package for the sub-audio squelch setup block: word decode, field layout, timing
package sasq_pkg;
  localparam logic [7:0]  SASQ_ADDR_CFG    = 8'hc8;
  localparam int          SASQ_WORD_W      = 16;
  // Header bits of each configuration word
  localparam int          SASQ_HDR_START   = 15;
  localparam int          SASQ_HDR_SHORT   = 14;
  localparam int          SASQ_HDR_BLK_HI  = 13;
  localparam int          SASQ_HDR_BLK_LO  = 12;
  localparam logic [2:0]  SASQ_BLK_SUB     = 3'h2;
  localparam logic [2:0]  SASQ_BLK_GAIN    = 3'h4;
  localparam logic [2:0]  SASQ_IDX_LEVEL   = 3'h0;
  localparam logic [2:0]  SASQ_IDX_DETECT  = 3'h1;
  localparam logic [2:0]  SASQ_IDX_CODE_LO = 3'h2;
  localparam logic [2:0]  SASQ_IDX_CODE_HI = 3'h3;
  localparam logic [2:0]  SASQ_IDX_DROP    = 3'h4;
  localparam logic [2:0]  SASQ_IDX_FGAIN   = 3'h0;
  // Field positions
  localparam int          SASQ_LVL_MSB     = 11;
  localparam int          SASQ_LONG_BIT    = 11;
  localparam int          SASQ_THR_MSB     = 9;
  localparam int          SASQ_THR_LSB     = 4;
  localparam int          SASQ_BW_MSB      = 3;
  localparam int          SASQ_CODE_HALF   = 12;
  localparam int          SASQ_DROP_MSB    = 11;
  localparam int          SASQ_DROP_LSB    = 8;
  localparam int          SASQ_FGAIN_MSB   = 13;
  // Code lengths, as last bit index
  localparam logic [4:0]  SASQ_LAST_SHORT  = 5'h16;
  localparam logic [4:0]  SASQ_LAST_LONG   = 5'h17;
  // Bandwidth codes in use
  localparam logic [3:0]  SASQ_BW_FIRST    = 4'h6;
  localparam logic [3:0]  SASQ_BW_LAST     = 4'hb;
  // Scaling laws: level per count and gain full scale
  localparam int          SASQ_LVL_SHIFT   = 14;
  localparam int          SASQ_GAIN_SHIFT  = 15;
  // Timing
  localparam int          SASQ_CLK_KHZ     = 100_000;
  localparam int          SASQ_STEP_MS     = 8;
  localparam int          SASQ_DERESP_MS   = 40;
  localparam logic [4:0]  SASQ_DERESP_STEPS = 5'(SASQ_DERESP_MS / SASQ_STEP_MS);
  localparam int          SASQ_PRE_W       = 24;
  localparam logic [11:0] SASQ_RST_LEVEL   = 12'h000;
  localparam logic [23:0] SASQ_RST_CODE    = 24'h00_0000;

  typedef struct packed {
    logic [11:0] tx_level;
    logic        long_code_select;
    logic [5:0]  threshold;
    logic [3:0]  bandwidth;
    logic [23:0] code;
    logic [3:0]  dropout;
    logic [13:0] input_attenuation_value;
  } sasq_cfg_t;

  typedef struct packed {
    sasq_cfg_t              cfg;
    logic [2:0]             blk;
    logic [2:0]             idx;
    logic [4:0]             tx_idx;
    logic                   tx_bit;
    logic [23:0]            rx_sr;
    logic [4:0]             rx_cnt;
    logic                   match;
    logic [SASQ_PRE_W-1:0]  pre;
    logic [4:0]             steps;
    logic                   loss;
  } sasq_state_t;
endpackage

/* core/sasq_scale.sv */
// Multiplies a signed sample by an unsigned coefficient and drops a fixed shift
module sasq_scale
  import sasq_pkg::*;
#(
  parameter int DW    = 16,
  parameter int CW    = 16,
  parameter int SHIFT = 14
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic signed [DW-1:0] i_sample,
  input  wire logic        [CW-1:0] i_coef,
  output logic signed      [DW-1:0] o_sample
);
  logic signed [DW+CW:0] prod;
  logic signed [DW+CW:0] shifted;

  always_comb begin
    prod    = i_sample * $signed({1'b0, i_coef});
    shifted = prod >>> SHIFT;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample <= '0;
    end else begin
      o_sample <= shifted[DW-1:0];
    end
  end
endmodule

/* core/sasq_top.sv */
// Sub-audio squelch setup: config words, code shifter, code matcher, drop-out timer
//
// Function
// [R1] Transmit sub-audio amplitude scales by level count over 16384 of supply.
// [R2] Detect config bit 11 selects 24-bit codes when set, 23-bit when clear.
// [R3] Bits 9..4 hold detect threshold, 2 mV rms per count.
// [R4] Bits 3..0 pick tone bandwidth from six codes, 6 up to 11.
// [R5] Host picks code 6 for split tones, code 8 for ordinary tone squelch.
// [R6] Lower code word holds bits 11..0, upper word bits 23..12.
// [R7] Code is sent and compared least significant bit first.
// [R8] Code bit 23 is ignored unless the long code select is set.
// [R9] Drop-out field bits 11..8 sets tolerated absence, 8 ms per step.
// [R10] De-response time follows drop-out time, about 40 ms longer.
// [R11] Input gain factor is (32768 minus attenuation value) over 32768.
// [R12] Host keeps fine input gain between 0 and -3.5 dB.
// [R13] Host writes the reserved gain word as all zeros.
// [R14] Loss flagged only after absence exceeds drop-out time; detection restarts it.
// [R15] Words hold their value until rewritten or reset.
module sasq_top
  import sasq_pkg::*;
#(
  parameter int STEP_CYC = SASQ_STEP_MS * SASQ_CLK_KHZ,
  parameter int DW       = 16
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_bus_reset,
  input  wire logic                 i_wr_valid,
  input  wire logic [7:0]           i_wr_addr,
  input  wire logic [15:0]          i_wr_data,
  input  wire logic                 i_tx_bit_tick,
  input  wire logic                 i_rx_bit_valid,
  input  wire logic                 i_rx_bit,
  input  wire logic                 i_subaudio_det,
  input  wire logic signed [DW-1:0] i_tone_sample,
  input  wire logic signed [DW-1:0] i_input_sample,
  output sasq_cfg_t                 o_cfg,
  output logic                      o_bw_valid,
  output logic                      o_tx_code_bit,
  output logic                      o_code_match,
  output logic                      o_subaudio_loss,
  output logic [4:0]                o_deresp_steps,
  output logic signed [DW-1:0]      o_tone_scaled,
  output logic signed [DW-1:0]      o_input_scaled
);
  localparam logic [SASQ_PRE_W-1:0] PRE_LAST = SASQ_PRE_W'(STEP_CYC - 1);

  sasq_state_t st_r;
  sasq_state_t st_nxt;
  logic        wr_hit;
  logic [2:0]  wr_blk;
  logic [2:0]  wr_idx;
  logic        wr_level;
  logic        wr_detect;
  logic        wr_code_lo;
  logic        wr_code_hi;
  logic        wr_drop;
  logic        wr_fgain;
  logic [4:0]  last_idx;
  logic [23:0] code_mask;
  logic [23:0] rx_aligned;
  logic [16:0] gain_coef;

  // A word with the start bit opens a block; following words step through it
  always_comb begin
    wr_hit = i_wr_valid && (i_wr_addr == SASQ_ADDR_CFG);
    if (i_wr_data[SASQ_HDR_START]) begin
      wr_idx = '0;
      if (i_wr_data[SASQ_HDR_SHORT]) begin
        wr_blk = {1'b0, i_wr_data[SASQ_HDR_BLK_HI:SASQ_HDR_BLK_LO]};
      end else begin
        wr_blk = SASQ_BLK_GAIN;
      end
    end else begin
      wr_blk = st_r.blk;
      // Index sticks at its top so a long block never wraps back onto word 0
      wr_idx = (&st_r.idx) ? st_r.idx : st_r.idx + 3'h1;                         // [R15]
    end
    wr_level   = wr_hit && wr_blk == SASQ_BLK_SUB  && wr_idx == SASQ_IDX_LEVEL;
    wr_detect  = wr_hit && wr_blk == SASQ_BLK_SUB  && wr_idx == SASQ_IDX_DETECT;
    wr_code_lo = wr_hit && wr_blk == SASQ_BLK_SUB  && wr_idx == SASQ_IDX_CODE_LO;
    wr_code_hi = wr_hit && wr_blk == SASQ_BLK_SUB  && wr_idx == SASQ_IDX_CODE_HI;
    wr_drop    = wr_hit && wr_blk == SASQ_BLK_SUB  && wr_idx == SASQ_IDX_DROP;
    wr_fgain   = wr_hit && wr_blk == SASQ_BLK_GAIN && wr_idx == SASQ_IDX_FGAIN;
  end

  always_comb begin
    last_idx  = st_r.cfg.long_code_select ? SASQ_LAST_LONG : SASQ_LAST_SHORT;  // [R2]
    code_mask = st_r.cfg.long_code_select ? 24'hff_ffff : 24'h7f_ffff;         // [R8]
    // 23-bit frames fill the shifter from bit 23 down, so drop the extra bit
    if (st_r.cfg.long_code_select) begin
      rx_aligned = st_r.rx_sr;
    end else begin
      rx_aligned = {1'b0, st_r.rx_sr[23:1]};
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (wr_hit) begin
      st_nxt.blk = wr_blk;
      st_nxt.idx = wr_idx;
    end
    if (wr_level) begin
      st_nxt.cfg.tx_level = i_wr_data[SASQ_LVL_MSB:0];                           // [R1]
    end
    if (wr_detect) begin
      st_nxt.cfg.long_code_select = i_wr_data[SASQ_LONG_BIT];                    // [R2]
      st_nxt.cfg.threshold        = i_wr_data[SASQ_THR_MSB:SASQ_THR_LSB];        // [R3]
      st_nxt.cfg.bandwidth        = i_wr_data[SASQ_BW_MSB:0];                    // [R4]
    end
    if (wr_code_lo) begin
      st_nxt.cfg.code[SASQ_CODE_HALF-1:0] = i_wr_data[SASQ_CODE_HALF-1:0];       // [R6]
    end
    if (wr_code_hi) begin
      st_nxt.cfg.code[23:SASQ_CODE_HALF] = i_wr_data[SASQ_CODE_HALF-1:0];        // [R6]
    end
    if (wr_drop) begin
      st_nxt.cfg.dropout = i_wr_data[SASQ_DROP_MSB:SASQ_DROP_LSB];               // [R9]
    end
    if (wr_fgain) begin
      st_nxt.cfg.input_attenuation_value = i_wr_data[SASQ_FGAIN_MSB:0];          // [R11]
    end

    // Transmit shifter walks the code from bit 0 upward and wraps
    if (i_tx_bit_tick) begin
      st_nxt.tx_bit = st_r.cfg.code[st_r.tx_idx];                                // [R7]
      if (st_r.tx_idx >= last_idx) begin
        st_nxt.tx_idx = '0;                                                      // [R8]
      end else begin
        st_nxt.tx_idx = st_r.tx_idx + 5'h1;
      end
    end

    // Received bits enter at the top so the first one of a 24-bit frame ends in bit 0
    if (i_rx_bit_valid) begin
      st_nxt.rx_sr = {i_rx_bit, st_r.rx_sr[23:1]};                               // [R7]
      if (st_r.rx_cnt <= last_idx) begin
        st_nxt.rx_cnt = st_r.rx_cnt + 5'h1;
      end
    end
    st_nxt.match = (st_r.rx_cnt > last_idx) &&
                   ((rx_aligned & code_mask) == (st_r.cfg.code & code_mask));    // [R8]

    // Absence timer counts 8 ms steps; any detection restarts it
    if (i_subaudio_det) begin
      st_nxt.pre   = '0;                                                         // [R14]
      st_nxt.steps = '0;
      st_nxt.loss  = 1'b0;
    end else begin
      if (st_r.pre >= PRE_LAST) begin
        st_nxt.pre = '0;
        if (st_r.steps != 5'h1f) begin
          st_nxt.steps = st_r.steps + 5'h1;                                      // [R9]
        end
      end else begin
        st_nxt.pre = st_r.pre + SASQ_PRE_W'(1);
      end
      st_nxt.loss = st_r.steps > {1'b0, st_r.cfg.dropout};                       // [R14]
    end

    if (i_bus_reset) begin
      st_nxt = '0;
      st_nxt.cfg.tx_level = SASQ_RST_LEVEL;
      st_nxt.cfg.code     = SASQ_RST_CODE;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;                                                            // [R15]
    end
  end

  assign gain_coef = 17'h0_8000 - {3'h0, st_r.cfg.input_attenuation_value};      // [R11]

  sasq_scale #(
    .DW    (DW),
    .CW    (12),
    .SHIFT (SASQ_LVL_SHIFT)
  ) u_tone_scale (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_sample (i_tone_sample),
    .i_coef   (st_r.cfg.tx_level),                                               // [R1]
    .o_sample (o_tone_scaled)
  );

  sasq_scale #(
    .DW    (DW),
    .CW    (17),
    .SHIFT (SASQ_GAIN_SHIFT)
  ) u_input_scale (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_sample (i_input_sample),
    .i_coef   (gain_coef),                                                       // [R11]
    .o_sample (o_input_scaled)
  );

  assign o_cfg           = st_r.cfg;
  assign o_bw_valid      = (st_r.cfg.bandwidth >= SASQ_BW_FIRST) &&
                           (st_r.cfg.bandwidth <= SASQ_BW_LAST);                  // [R4]
  assign o_tx_code_bit   = st_r.tx_bit;
  assign o_code_match    = st_r.match;
  assign o_subaudio_loss = st_r.loss;
  assign o_deresp_steps  = {1'b0, st_r.cfg.dropout} + SASQ_DERESP_STEPS;         // [R10]

  a_long_sel_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
    wr_detect && !i_bus_reset |=> o_cfg.long_code_select == $past(i_wr_data[11]))
    else $error("long code select not taken from bit 11");

  a_thresh_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R3]
    wr_detect && !i_bus_reset |=> o_cfg.threshold == $past(i_wr_data[9:4]))
    else $error("detect threshold not taken from bits 9..4");

  a_bw_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R4]
    wr_detect && !i_bus_reset |=> o_cfg.bandwidth == $past(i_wr_data[3:0]))
    else $error("bandwidth not taken from bits 3..0");

  a_code_upper_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R6]
    wr_code_hi && !i_bus_reset |=> o_cfg.code[23:12] == $past(i_wr_data[11:0]))
    else $error("upper code word not stored in bits 23..12");

  a_tx_lsb_first: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R7]
    i_tx_bit_tick && st_r.tx_idx == 5'h0 && !i_bus_reset
      |=> o_tx_code_bit == $past(st_r.cfg.code[0]))
    else $error("code does not start with bit 0");

  a_short_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R8]
    i_tx_bit_tick && !st_r.cfg.long_code_select && st_r.tx_idx == 5'h16 && !i_bus_reset
      |=> st_r.tx_idx == 5'h0)
    else $error("23-bit code did not wrap after bit 22");

  a_drop_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R9]
    wr_drop && !i_bus_reset |=> o_cfg.dropout == $past(i_wr_data[11:8]))
    else $error("drop-out time not taken from bits 11..8");

  a_loss_restart: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R14]
    i_subaudio_det |=> !o_subaudio_loss ##0 st_r.steps == 5'h0)
    else $error("detection did not clear loss and restart count");

  a_loss_late: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R14]
    $rose(o_subaudio_loss) |-> $past(st_r.steps) > {1'b0, $past(o_cfg.dropout)})
    else $error("loss raised before drop-out time elapsed");

  a_level_hold: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
    !wr_level && !i_bus_reset |=> $stable(o_cfg.tx_level))
    else $error("transmit level changed without a write");

  a_level_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R1]
    wr_level && !i_bus_reset |=> o_cfg.tx_level == $past(i_wr_data[SASQ_LVL_MSB:0]))
    else $error("transmit level not taken from bits 11..0");

  a_code_lower_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R6]
    wr_code_lo && !i_bus_reset |=> o_cfg.code[11:0] == $past(i_wr_data[11:0]))
    else $error("lower code word not stored in bits 11..0");

  a_long_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
    i_tx_bit_tick && st_r.cfg.long_code_select && !i_bus_reset &&
      st_r.tx_idx == SASQ_LAST_LONG |=> st_r.tx_idx == 5'h0)
    else $error("24-bit code did not wrap after bit 23");

  a_short_top_skip: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R8]
    i_tx_bit_tick && !st_r.cfg.long_code_select && !i_bus_reset
      |=> st_r.tx_idx != SASQ_LAST_LONG)
    else $error("23-bit code reached bit 23");

  a_match_len: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R7]
    o_code_match |-> $past(st_r.rx_cnt) > $past(last_idx))
    else $error("match flagged before a full code was received");

  a_steps_count: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R9]
    !i_subaudio_det && !i_bus_reset && st_r.pre >= PRE_LAST && st_r.steps != 5'h1f
      |=> st_r.steps == $past(st_r.steps) + 5'h1)
    else $error("drop-out step not counted");

  a_deresp_offset: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
    o_deresp_steps * SASQ_STEP_MS == o_cfg.dropout * SASQ_STEP_MS + SASQ_DERESP_MS)
    else $error("de-response time not drop-out time plus offset");

  a_gain_write: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R11]
    wr_fgain && !i_bus_reset
      |=> o_cfg.input_attenuation_value == $past(i_wr_data[SASQ_FGAIN_MSB:0]))
    else $error("attenuation not taken from bits 13..0");

  a_loss_needs_absence: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R14]
    o_subaudio_loss |-> $past(!i_subaudio_det))
    else $error("loss flagged while sub-audio was detected");

  a_bw_flag: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R4]
    o_bw_valid == (o_cfg.bandwidth[3] ? (o_cfg.bandwidth[2:0] <= 3'h3)
                                      : (o_cfg.bandwidth[3:1] == 3'h3)))
    else $error("bandwidth flag disagrees with the six codes");

  a_idx_sticks: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
    wr_hit && !i_wr_data[SASQ_HDR_START] && (&st_r.idx) && !i_bus_reset
      |=> (&st_r.idx))
    else $error("word index wrapped inside a block");

  a_bus_reset_clear: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
    i_bus_reset |=> o_cfg.tx_level == SASQ_RST_LEVEL && o_cfg.code == SASQ_RST_CODE &&
      !o_subaudio_loss && !o_code_match)
    else $error("bus reset did not clear the block");

  a_foreign_addr: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
    (!i_wr_valid || i_wr_addr != SASQ_ADDR_CFG) && !i_bus_reset |=> $stable(o_cfg))
    else $error("configuration changed without a write");
endmodule

/* verif/sasq_host_model.sv */
// Host controller model: writes configuration words on the write port
module sasq_host_model
  import sasq_pkg::*;
(
  input  wire logic   i_clk,
  output logic        o_wr_valid,
  output logic [7:0]  o_wr_addr,
  output logic [15:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_wr_valid = 1'b0;
    o_wr_addr  = 8'h00;
    o_wr_data  = 16'h0000;
  end

  // Released lines show the inverse of the last word, never a stale copy
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_wr_valid = 1'b1;
    o_wr_addr  = a;
    o_wr_data  = d;
    @(negedge i_clk);
    o_wr_valid = 1'b0;
    o_wr_addr  = ~a;
    o_wr_data  = ~d;
  endtask

  function automatic logic [3:0] pick_bw(input logic split);
    return split ? SASQ_BW_FIRST : 4'h8;
  endfunction

  // Attenuation is clipped to the 3.5 dB limit, then the spare word follows as zero
  task automatic put_gain(input logic [13:0] att);
    logic [13:0] a;
    a = (att > 14'h2a75) ? 14'h2a75 : att;
    put(SASQ_ADDR_CFG, {2'h2, a});
    put(SASQ_ADDR_CFG, 16'h0000);
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking testbench for the sub-audio squelch setup block
module tb_top
  import sasq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 4;
  logic               clk, resetn, bus_rst, tick, rxv, rxb, det;
  logic               wv, bwv, txb, match, loss;
  logic [7:0]         wa;
  logic [15:0]        wd;
  logic [4:0]         dsteps;
  logic signed [15:0] tone, insmp, tone_o, in_o;
  sasq_cfg_t          cfg;
  int                 failures, total_checks;

  sasq_host_model sasq_host_model_i (.i_clk(clk), .o_wr_valid(wv), .o_wr_addr(wa),
    .o_wr_data(wd));
  sasq_top #(.STEP_CYC(S), .DW(16)) sasq_top_i (.i_clk(clk), .i_resetn(resetn),
    .i_bus_reset(bus_rst), .i_wr_valid(wv), .i_wr_addr(wa), .i_wr_data(wd),
    .i_tx_bit_tick(tick), .i_rx_bit_valid(rxv), .i_rx_bit(rxb), .i_subaudio_det(det),
    .i_tone_sample(tone), .i_input_sample(insmp), .o_cfg(cfg), .o_bw_valid(bwv),
    .o_tx_code_bit(txb), .o_code_match(match), .o_subaudio_loss(loss),
    .o_deresp_steps(dsteps), .o_tone_scaled(tone_o), .o_input_scaled(in_o));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic w(input logic [15:0] d);
    sasq_host_model_i.put(SASQ_ADDR_CFG, d);
  endtask

  // Level 0x800, threshold 0x25, split-tone bandwidth, drop-out 2 steps
  task automatic cfg_sub(input logic lg, input logic [23:0] c);
    w(16'he800);
    w({4'h6, lg, 7'h25, sasq_host_model_i.pick_bw(1'b1)});
    w({4'h6, c[11:0]});
    w({4'h6, c[23:12]});
    w(16'h6200);
  endtask

  task automatic txrun(input logic [23:0] c, input int n);
    for (int i = 0; i <= n; i++) begin
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      @(negedge clk);
      chk(32'(txb), 32'(c[i % n]), "tx code bit");
    end
  endtask

  task automatic rxrun(input logic [23:0] c, input int n, input logic exp);
    for (int i = 0; i < n; i++) begin
      rxv = 1'b1;
      rxb = c[i];
      @(negedge clk);
    end
    rxv = 1'b0;
    rxb = ~rxb;
    repeat (3) @(negedge clk);
    chk(32'(match), 32'(exp), "code match");
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    failures = 0;
    total_checks = 0;
    resetn = 1'b0;
    bus_rst = 1'b0;
    tick = 1'b0;
    rxv = 1'b0;
    rxb = 1'b0;
    det = 1'b1;
    tone = 16'h03e8;
    insmp = 16'h03e8;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk(32'(|cfg), 32'h0, "reset config");
    chk(32'(dsteps), 32'h5, "deresp at reset");
    cfg_sub(1'b0, 24'h80_5a3c);
    chk(32'(cfg.tx_level), 32'h800, "level");
    chk(32'(cfg.long_code_select), 32'h0, "long select");
    chk(32'(cfg.threshold), 32'h25, "threshold");
    chk(32'(cfg.code), 32'h80_5a3c, "code");
    chk(32'(cfg.dropout), 32'h2, "dropout");
    chk(32'(dsteps), 32'h7, "deresp steps");
    chk(32'(tone_o), 32'h007d, "tone scaled");
    txrun(24'h80_5a3c, 23);
    rxrun(24'h00_5a3c, 23, 1'b1);
    rxrun(24'h00_5a3d, 23, 1'b0);
    sasq_host_model_i.put_gain(14'h0800);
    chk(32'(cfg.input_attenuation_value), 32'h0800, "attenuation");
    chk(32'(in_o), 32'h03a9, "input scaled");
    sasq_host_model_i.put(8'hc9, 16'h8100);
    chk(32'(cfg.input_attenuation_value), 32'h0800, "other address");
    // Remaining words of the gain block must not wrap onto the input gain word
    for (int k = 0; k < 7; k++) begin
      w(16'h0123);
    end
    chk(32'(cfg.input_attenuation_value), 32'h0800, "long gain block");
    det = 1'b0;
    repeat (6) @(negedge clk);
    det = 1'b1;
    @(negedge clk);
    det = 1'b0;
    repeat (10) @(negedge clk);
    chk(32'(loss), 32'h0, "loss early");
    repeat (6) @(negedge clk);
    chk(32'(loss), 32'h1, "loss late");
    det = 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(loss), 32'h0, "loss cleared");
    bus_rst = 1'b1;
    @(negedge clk);
    bus_rst = 1'b0;
    chk(32'(|cfg), 32'h0, "bus reset");
    cfg_sub(1'b1, 24'h80_5a3c);
    chk(32'(cfg.long_code_select), 32'h1, "long select");
    txrun(24'h80_5a3c, 24);
    rxrun(24'h80_5a3c, 24, 1'b1);
    rxrun(24'h00_5a3c, 24, 1'b0);
    for (int b = 0; b < 16; b++) begin
      w(16'he800);
      w(16'h6250 | 16'(b));
      chk(32'(bwv), 32'(b >= 6 && b <= 11), "bandwidth valid");
      chk(32'(cfg.bandwidth), 32'(b), "bandwidth");
    end
    // Mid-run power-on reset, then a write on the second rising edge after release
    resetn = 1'b0;
    @(negedge clk);
    chk(32'(|cfg), 32'h0, "async reset");
    chk(32'(tone_o), 32'h0, "scaled at reset");
    chk(32'(dsteps), 32'h5, "deresp after reset");
    resetn = 1'b1;
    w(16'he123);
    chk(32'(cfg.tx_level), 32'h123, "level after reset");
    summarize();
  end
endmodule
